// File: src/itr_defs.svh
// itr_defs.svh: constants for the two-wire register access link and both of its ends.
// assumes: included by bare name from the package and the design files.
`ifndef ITR_DEFS_SVH
`define ITR_DEFS_SVH

// target address and direction bit of the first byte
`define ITR_TGT_ADDR  7'h0F
`define ITR_RW_WRITE  1'b0
`define ITR_RW_READ   1'b1

// register window reached through the pointer
`define ITR_REG_BASE  8'h0C
`define ITR_NREG      23
`define ITR_PTR_MSB   7

// byte framing and acknowledge levels
`define ITR_BYTE_BITS 4'h8
`define ITR_ACK       1'b0
`define ITR_NACK      1'b1
`define ITR_RX_FILL   8'hFF

// controller bit phases, one quarter of the serial clock period each
`define ITR_PH_SDA    2'h0
`define ITR_PH_RISE   2'h1
`define ITR_PH_HIGH   2'h2
`define ITR_PH_FALL   2'h3

// least serial clock period and system clock period, in ns
`define ITR_T_SCL_NS  2500
`define ITR_T_CLK_NS  20
// least time, so the quarter period rounds up
`define ITR_QTR_CYC   ((`ITR_T_SCL_NS + 4 * `ITR_T_CLK_NS - 1) / (4 * `ITR_T_CLK_NS))

`endif

// File: src/itr_pkg.sv
// itr_pkg: state types shared by the target and controller ends.
// assumes: itr_defs.svh on the include path.
`include "itr_defs.svh"

package itr_pkg;

  // target link engine states
  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_RX   = 6'h02,
    D_ACK  = 6'h04,
    D_TX   = 6'h08,
    D_RACK = 6'h10,
    D_SKIP = 6'h20
  } itr_dst_t;

  // which byte of a write transfer the target expects next
  typedef enum logic [2:0] {
    P_ADDR = 3'h1,
    P_PTR  = 3'h2,
    P_DATA = 3'h4
  } itr_ph_t;

  // controller sequence states
  typedef enum logic [8:0] {
    H_IDLE   = 9'h001,
    H_START  = 9'h002,
    H_ADDRW  = 9'h004,
    H_PTR    = 9'h008,
    H_WDAT   = 9'h010,
    H_RSTART = 9'h020,
    H_ADDRR  = 9'h040,
    H_RDAT   = 9'h080,
    H_STOP   = 9'h100
  } itr_hst_t;

endpackage

// File: src/itr_link_if.sv
// itr_link_if: the two open-drain wires between controller and target.
// assumes: a pull-up on each wire; a wire reads low when any end drives it low.
`timescale 1ns/10ps
`default_nettype none

interface itr_link_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic scl_d_o;
  logic scl_d_oe;
  logic sda_d_o;
  logic sda_d_oe;
  wire logic scl;
  wire logic sda;

  // wired-and with pull-up
  assign scl = ~((scl_h_oe & ~scl_h_o) | (scl_d_oe & ~scl_d_o));
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport host (input scl, input sda, output scl_h_o, output scl_h_oe, output sda_h_o, output sda_h_oe);
  modport dev  (input scl, input sda, output scl_d_o, output scl_d_oe, output sda_d_o, output sda_d_oe);
endinterface

`default_nettype wire

// File: src/itr_target.sv
// itr_target: serial target end; register window behind a pointer, burst access.
// assumes: LCLK oversamples the wires (several LCLK edges per scl phase);
// CLK domain only sees completed writes and the bus-busy level.
// Operation
// - target only; drives scl low to stall
// - controller starts, clocks and ends transfers
// - receiver may hold scl low to stall
// - eight-bit bytes, most significant bit first
// - both wires high means bus idle
// - sda falls with scl high: start
// - first byte: address plus direction bit
// - selected only on exact address match
// - receiver pulls sda low for acknowledge
// - sda rises with scl high: stop
// - controller programs control registers after power-up
// - write: address, pointer, data, each acknowledged
// - pointer sent with top bit clear
// - pointer advances after each written byte
// - read: pointer, repeated start, address with read
// - controller leaves last read byte unacknowledged
// - read burst walks consecutive registers
// - twenty-three eight-bit registers behind the pointer
`timescale 1ns/10ps
`default_nettype none
`include "itr_defs.svh"

module itr_target
  import itr_pkg::*;
#(
  parameter logic [6:0] TGT_ADDR = `ITR_TGT_ADDR,
  parameter int         NREG     = `ITR_NREG,
  parameter logic [7:0] BASE     = `ITR_REG_BASE
) (
  input  wire logic   CLK,
  input  wire logic   RESETN,
  input  wire logic   LCLK,
  itr_link_if.dev     LINK,
  output logic        WR_STB,
  output logic [7:0]  WR_PTR,
  output logic [7:0]  WR_DATA,
  output logic        BUS_BUSY
);

  // link side state, all on LCLK
  typedef struct packed {
    logic [2:0]           scl;
    logic [2:0]           sda;
    logic [1:0]           ack;
    itr_dst_t             st;
    itr_ph_t              ph;
    logic                 rw;
    logic                 hold;
    logic                 bus;
    logic                 scl_oe;
    logic                 sda_oe;
    logic                 wtgl;
    logic [3:0]           cnt;
    logic [7:0]           sh;
    logic [7:0]           ptr;
    logic [7:0]           widx;
    logic [7:0]           wdat;
    logic [NREG-1:0][7:0] regs;
  } itr_lnk_t;

  // user side state, all on CLK
  typedef struct packed {
    logic [2:0] tgl;
    logic [1:0] bus;
    logic       stb;
    logic [7:0] idx;
    logic [7:0] dat;
  } itr_usr_t;

  itr_lnk_t l;
  itr_lnk_t next_l;
  itr_usr_t u;
  itr_usr_t next_u;

  // pointer lies inside the register window
  function automatic logic in_win(input logic [7:0] p);
    logic [7:0] d;
    d = 8'(p - BASE);
    in_win = (p >= BASE) && (int'(d) < NREG);
  endfunction

  // pointer to array slot
  function automatic logic [7:0] slot(input logic [7:0] p);
    slot = 8'(p - BASE);
  endfunction

  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       wr_busy;
  logic [7:0] rd_byte;

  // edges taken from second and third stages only; the first stage feeds nothing else
  assign scl_rise = l.scl[1] & ~l.scl[2];
  assign scl_fall = ~l.scl[1] & l.scl[2];
  assign start_c  = l.scl[1] & l.scl[2] & l.sda[2] & ~l.sda[1];
  assign stop_c   = l.scl[1] & l.scl[2] & ~l.sda[2] & l.sda[1];
  // a write still crossing to CLK keeps the next byte stalled
  assign wr_busy  = l.wtgl ^ l.ack[1];
  // outside the window reads as zero
  assign rd_byte  = in_win(l.ptr) ? l.regs[slot(l.ptr)] : 8'h00;

  // link engine
  always_comb begin
    next_l     = l;
    next_l.scl = {l.scl[1:0], LINK.scl};
    next_l.sda = {l.sda[1:0], LINK.sda};
    next_l.ack = {l.ack[0], u.tgl[2]};
    if (start_c) begin
      // start and repeated start both land here; the pointer survives
      next_l.st     = D_RX;
      next_l.ph     = P_ADDR;
      next_l.cnt    = 4'h0;
      next_l.bus    = 1'b1;
      next_l.sda_oe = 1'b0;
      next_l.scl_oe = 1'b0;
      next_l.hold   = 1'b0;
    end else if (stop_c) begin
      next_l.st     = D_IDLE;
      next_l.bus    = 1'b0;
      next_l.sda_oe = 1'b0;
      next_l.scl_oe = 1'b0;
      next_l.hold   = 1'b0;
    end else begin
      case (l.st)
        D_RX: begin
          if (scl_rise) begin
            // most significant bit arrives first
            next_l.sh  = {l.sh[6:0], l.sda[1]};
            next_l.cnt = 4'(l.cnt + 4'h1);
          end else if (scl_fall && l.cnt == `ITR_BYTE_BITS) begin
            // byte complete: acknowledge during the ninth clock
            next_l.st     = D_ACK;
            next_l.sda_oe = 1'b1;
            case (l.ph)
              P_ADDR: begin
                if (l.sh[7:1] != TGT_ADDR) begin
                  next_l.st     = D_SKIP;
                  next_l.sda_oe = 1'b0;
                end else begin
                  next_l.rw = l.sh[0];
                end
              end
              P_PTR: next_l.ptr = l.sh;
              default: begin
                // store, report to CLK side, then advance
                if (in_win(l.ptr)) begin
                  next_l.regs[slot(l.ptr)] = l.sh;
                end
                next_l.widx = l.ptr;
                next_l.wdat = l.sh;
                next_l.wtgl = ~l.wtgl;
                next_l.ptr  = 8'(l.ptr + 8'h01);
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall || l.hold) begin
            if (wr_busy) begin
              // scl is already low here, so holding it adds no edge
              next_l.hold   = 1'b1;
              next_l.scl_oe = 1'b1;
            end else begin
              next_l.hold   = 1'b0;
              next_l.scl_oe = 1'b0;
              if (l.rw == `ITR_RW_READ) begin
                // first data bit goes out while scl is low
                next_l.st     = D_TX;
                next_l.sda_oe = ~rd_byte[7];
                next_l.sh     = {rd_byte[6:0], 1'b0};
                next_l.cnt    = 4'h1;
              end else begin
                next_l.st     = D_RX;
                next_l.sda_oe = 1'b0;
                next_l.cnt    = 4'h0;
                next_l.ph     = (l.ph == P_ADDR) ? P_PTR : P_DATA;
              end
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (l.cnt == `ITR_BYTE_BITS) begin
              // let go for the controller's acknowledge
              next_l.st     = D_RACK;
              next_l.sda_oe = 1'b0;
            end else begin
              next_l.sda_oe = ~l.sh[7];
              next_l.sh     = {l.sh[6:0], 1'b0};
              next_l.cnt    = 4'(l.cnt + 4'h1);
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            if (l.sda[1] == `ITR_NACK) begin
              next_l.st = D_SKIP;
            end else begin
              // acknowledged: next register follows
              next_l.ptr = 8'(l.ptr + 8'h01);
              next_l.st  = D_ACK;
            end
          end
        end
        default: begin
          // idle and skip ignore everything but start and stop
          next_l.sda_oe = 1'b0;
          next_l.scl_oe = 1'b0;
        end
      endcase
    end
  end

  // write notice crossing: toggle, then idx/data taken while known stable
  always_comb begin
    next_u     = u;
    next_u.tgl = {u.tgl[1:0], l.wtgl};
    next_u.bus = {u.bus[0], l.bus};
    next_u.stb = u.tgl[1] ^ u.tgl[2];
    if (u.tgl[1] ^ u.tgl[2]) begin
      next_u.idx = l.widx;
      next_u.dat = l.wdat;
    end
  end

  always_ff @(posedge LCLK or negedge RESETN) begin
    if (!RESETN) begin
      l    <= '0;
      l.st <= D_IDLE;
      l.ph <= P_ADDR;
    end else begin
      l <= next_l;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      u <= '0;
    end else begin
      u <= next_u;
    end
  end

  // open-drain: output value fixed low, enable carries the data
  assign LINK.scl_d_o  = 1'b0;
  assign LINK.sda_d_o  = 1'b0;
  assign LINK.scl_d_oe = l.scl_oe;
  assign LINK.sda_d_oe = l.sda_oe;
  assign WR_STB        = u.stb;
  assign WR_PTR        = u.idx;
  assign WR_DATA       = u.dat;
  assign BUS_BUSY      = u.bus[1];

endmodule

`default_nettype wire

// File: src/itr_ctrl.sv
// itr_ctrl: controller end; runs one register write or read burst per command.
// assumes: one target on the link; scl made here by dividing CLK.
`timescale 1ns/10ps
`default_nettype none
`include "itr_defs.svh"

module itr_ctrl
  import itr_pkg::*;
#(
  parameter logic [6:0] TGT_ADDR = `ITR_TGT_ADDR,
  parameter int         QTR      = `ITR_QTR_CYC,
  parameter int         QW       = 8,
  parameter int         LW       = 8
) (
  input  wire logic          CLK,
  input  wire logic          RESETN,
  itr_link_if.host           LINK,
  input  wire logic          CMD_VALID,
  input  wire logic          CMD_RD,
  input  wire logic [7:0]    CMD_PTR,
  input  wire logic [LW-1:0] CMD_LEN,
  input  wire logic [7:0]    WDATA,
  output logic               CMD_READY,
  output logic               WTAKE,
  output logic [7:0]         RDATA,
  output logic               RVALID,
  output logic               DONE,
  output logic               NACK
);

  typedef struct packed {
    logic [1:0]    scl;
    logic [1:0]    sda;
    itr_hst_t      st;
    logic [1:0]    ph;
    logic [QW-1:0] q;
    logic [3:0]    bitc;
    logic [8:0]    sh;
    logic [8:0]    rx;
    logic [7:0]    ptr;
    logic [7:0]    rdata;
    logic [LW-1:0] left;
    logic          rd;
    logic          rdy;
    logic          done;
    logic          nack;
    logic          rvalid;
    logic          wtake;
    logic          scl_oe;
    logic          sda_oe;
  } itr_hreg_t;

  itr_hreg_t h;
  itr_hreg_t next_h;

  logic tick;
  logic stall;
  logic cond;
  logic bad;

  // scl is let go at the end of the rise quarter; the high quarter waits until the wire
  // is seen high, so a target holding scl low freezes it, and our own pull never does
  assign tick  = (h.q == QW'(QTR - 1));
  assign stall = (h.ph == `ITR_PH_HIGH) && !h.scl[1];
  assign cond  = (h.st == H_START) || (h.st == H_RSTART) || (h.st == H_STOP);
  assign bad   = (h.rx[0] == `ITR_NACK);

  // sequence and bit engine
  always_comb begin
    next_h        = h;
    next_h.scl    = {h.scl[0], LINK.scl};
    next_h.sda    = {h.sda[0], LINK.sda};
    next_h.done   = 1'b0;
    next_h.rvalid = 1'b0;
    next_h.wtake  = 1'b0;
    if (h.st == H_IDLE) begin
      if (CMD_VALID) begin
        // every transfer begins here
        next_h.st   = H_START;
        next_h.rd   = CMD_RD;
        next_h.ptr  = {1'b0, CMD_PTR[`ITR_PTR_MSB-1:0]};
        next_h.left = CMD_LEN;
        next_h.nack = 1'b0;
        next_h.rdy  = 1'b0;
        next_h.ph   = `ITR_PH_SDA;
        next_h.q    = '0;
      end
    end else if (!tick) begin
      next_h.q = QW'(h.q + 1'b1);
    end else if (!stall) begin
      next_h.q  = '0;
      next_h.ph = 2'(h.ph + 2'h1);
      case (h.ph)
        `ITR_PH_SDA: begin
          // sda moves only with scl low
          next_h.sda_oe = cond ? (h.st == H_STOP) : ~h.sh[8];
        end
        `ITR_PH_RISE: next_h.scl_oe = 1'b0;
        `ITR_PH_HIGH: begin
          if (cond) begin
            next_h.sda_oe = (h.st != H_STOP);
          end else begin
            next_h.rx = {h.rx[7:0], h.sda[1]};
          end
        end
        default: begin
          if (h.st == H_STOP) begin
            // scl stays released; both wires high again
            next_h.st   = H_IDLE;
            next_h.rdy  = 1'b1;
            next_h.done = 1'b1;
          end else begin
            next_h.scl_oe = 1'b1;
            if (h.st == H_START) begin
              next_h.st = H_ADDRW;
              next_h.sh = {TGT_ADDR, `ITR_RW_WRITE, 1'b1};
            end else if (h.st == H_RSTART) begin
              next_h.st = H_ADDRR;
              next_h.sh = {TGT_ADDR, `ITR_RW_READ, 1'b1};
            end else if (h.bitc != `ITR_BYTE_BITS) begin
              next_h.sh   = {h.sh[7:0], 1'b1};
              next_h.bitc = 4'(h.bitc + 4'h1);
            end else begin
              // ninth bit done: the byte and its acknowledge are complete
              next_h.bitc = 4'h0;
              next_h.st   = H_STOP;
              case (h.st)
                H_ADDRW: begin
                  next_h.nack = bad;
                  if (!bad) begin
                    next_h.st = H_PTR;
                    next_h.sh = {h.ptr, 1'b1};
                  end
                end
                H_PTR: begin
                  next_h.nack = bad;
                  if (!bad && h.rd) begin
                    next_h.st = H_RSTART;
                  end else if (!bad) begin
                    next_h.st    = H_WDAT;
                    next_h.sh    = {WDATA, 1'b1};
                    next_h.wtake = 1'b1;
                  end
                end
                H_WDAT: begin
                  next_h.nack = bad;
                  next_h.left = LW'(h.left - LW'(1));
                  if (!bad && h.left != LW'(1)) begin
                    next_h.st    = H_WDAT;
                    next_h.sh    = {WDATA, 1'b1};
                    next_h.wtake = 1'b1;
                  end
                end
                H_ADDRR: begin
                  next_h.nack = bad;
                  if (!bad) begin
                    next_h.st = H_RDAT;
                    next_h.sh = {`ITR_RX_FILL, (h.left == LW'(1)) ? `ITR_NACK : `ITR_ACK};
                  end
                end
                default: begin
                  // read byte: answer acked all but the last
                  next_h.rdata  = h.rx[8:1];
                  next_h.rvalid = 1'b1;
                  next_h.left   = LW'(h.left - LW'(1));
                  if (h.left != LW'(1)) begin
                    next_h.st = H_RDAT;
                    next_h.sh = {`ITR_RX_FILL, (h.left == LW'(2)) ? `ITR_NACK : `ITR_ACK};
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      h     <= '0;
      h.st  <= H_IDLE;
      h.rdy <= 1'b1;
    end else begin
      h <= next_h;
    end
  end

  assign LINK.scl_h_o  = 1'b0;
  assign LINK.sda_h_o  = 1'b0;
  assign LINK.scl_h_oe = h.scl_oe;
  assign LINK.sda_h_oe = h.sda_oe;
  assign CMD_READY     = h.rdy;
  assign WTAKE         = h.wtake;
  assign RDATA         = h.rdata;
  assign RVALID        = h.rvalid;
  assign DONE          = h.done;
  assign NACK          = h.nack;

endmodule

`default_nettype wire

// File: verif/itr_link_asserts.sv
// itr_link_asserts: wire-level checks on the target end of the link.
// assumes: instanced beside the interface that joins both ends, on the target's link clock.
`timescale 1ns/10ps
`default_nettype none

module itr_link_asserts (
  input wire logic LCLK,
  input wire logic RESETN,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_d_o,
  input wire logic scl_d_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe
);
  default clocking cb @(posedge LCLK); endclocking
  default disable iff (!RESETN);

  // frame edges as seen on the wires
  sequence start_seq;
    scl && $fell(sda);
  endsequence
  sequence stop_seq;
    scl && $rose(sda);
  endsequence

  a_drive_low_only: assert property (scl_d_o == 1'b0 && sda_d_o == 1'b0)
    else $error("target drives a wire high");
  a_stretch_when_low: assert property ($rose(scl_d_oe) |-> !$past(scl))
    else $error("target pulled scl while it was high");
  // a stall longer than the write notice crossing means a stuck hold
  a_stretch_bounded: assert property (scl_d_oe |-> ##[1:64] !scl_d_oe)
    else $error("target holds scl too long");
  a_idle_no_stretch: assert property (scl && sda && $past(scl) && $past(sda) |-> !scl_d_oe)
    else $error("target drives scl on an idle bus");
  a_start_quiet: assert property (start_seq |-> !sda_d_oe [*8])
    else $error("target drives sda right after a start");
  a_ack_held: assert property ($rose(sda_d_oe) |-> !scl ##1 sda_d_oe [*4])
    else $error("target sda pull not held");
  a_stop_released: assert property (stop_seq |-> ##1 (!sda_d_oe && !scl_d_oe) [*4])
    else $error("target drives a wire after a stop");
  // the sampling skew is a few link clocks, the high phase far longer
  a_sda_stable_high: assert property ($rose(scl) |-> $stable(sda_d_oe) [*8])
    else $error("target sda moved while scl high");
endmodule

`default_nettype wire

// File: verif/testbench.sv
// testbench: controller and target joined on one link, plus a second pair whose controller
// uses a foreign address. assumes: design files and itr_defs.svh compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "itr_defs.svh"

module testbench;
  import itr_pkg::*;
  localparam logic [7:0] LASTP = 8'(`ITR_REG_BASE + `ITR_NREG - 1);

  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_rd = 1'b0;
  logic [7:0]  cmd_ptr = 8'h00;
  logic [7:0]  cmd_len = 8'h01;
  logic [7:0]  wdata = 8'h00;
  logic        cmd_valid_b = 1'b0;
  logic        cmd_ready, wtake, rvalid, done, nack, wr_stb, bus_busy;
  logic [7:0]  rdata, wr_ptr, wr_data;
  logic        done_b, nack_b, wr_stb_b;
  logic [7:0]  wbuf [8];
  logic [7:0]  rq [$];
  logic [15:0] nq [$];
  logic        seen_busy;
  int          stray = 0;
  int          err_count = 0;
  int          cmp_count = 0;

  // link clock unrelated in phase to the user clock
  always #10 clk = ~clk;
  always #7.5 lclk = ~lclk;

  itr_link_if u_link ();
  itr_link_if u_link_b ();

  itr_ctrl #(.QTR(16)) u_itr_ctrl (.CLK(clk), .RESETN(resetn), .LINK(u_link), .CMD_VALID(cmd_valid),
    .CMD_RD(cmd_rd), .CMD_PTR(cmd_ptr), .CMD_LEN(cmd_len), .WDATA(wdata), .CMD_READY(cmd_ready),
    .WTAKE(wtake), .RDATA(rdata), .RVALID(rvalid), .DONE(done), .NACK(nack));
  itr_target u_itr_target (.CLK(clk), .RESETN(resetn), .LCLK(lclk), .LINK(u_link), .WR_STB(wr_stb),
    .WR_PTR(wr_ptr), .WR_DATA(wr_data), .BUS_BUSY(bus_busy));
  // second pair: controller calls an address one below the target's own; it shares the
  // command fields of the first pair, which stay idle while it runs
  itr_ctrl #(.TGT_ADDR(7'h0E), .QTR(16)) u_itr_ctrl_b (.CLK(clk), .RESETN(resetn), .LINK(u_link_b),
    .CMD_VALID(cmd_valid_b), .CMD_RD(cmd_rd), .CMD_PTR(cmd_ptr), .CMD_LEN(cmd_len), .WDATA(wdata),
    .CMD_READY(), .WTAKE(), .RDATA(), .RVALID(), .DONE(done_b), .NACK(nack_b));
  itr_target u_itr_target_b (.CLK(clk), .RESETN(resetn), .LCLK(lclk), .LINK(u_link_b),
    .WR_STB(wr_stb_b), .WR_PTR(), .WR_DATA(), .BUS_BUSY());

  itr_link_asserts u_itr_link_asserts (.LCLK(lclk), .RESETN(resetn), .scl(u_link.scl), .sda(u_link.sda),
    .scl_d_o(u_link.scl_d_o), .scl_d_oe(u_link.scl_d_oe), .sda_d_o(u_link.sda_d_o),
    .sda_d_oe(u_link.sda_d_oe));

  // collect write notices; flops update after this sample, so no race
  always @(posedge clk) begin
    if (wr_stb === 1'b1) nq.push_back({wr_ptr, wr_data});
    if (wr_stb_b === 1'b1) stray++;
  end

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("TB: %0d mismatches in %0d compares", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one command; wdata refilled on each take, read bytes queued, bounded wait on done
  task automatic run_cmd(input logic rd, input logic [7:0] ptr, input logic [7:0] len);
    int k;
    int n;
    k = 1;
    n = 0;
    rq.delete();
    seen_busy = 1'b0;
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_rd <= rd;
    cmd_ptr <= ptr;
    cmd_len <= len;
    wdata <= wbuf[0];
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
      if (bus_busy === 1'b1) seen_busy = 1'b1;
      if (wtake === 1'b1) begin
        wdata <= wbuf[k];
        k++;
      end
      if (rvalid === 1'b1) rq.push_back(rdata);
    end
    check8("done seen", 8'h01, {7'h00, done});
    check8("nack", 8'h00, {7'h00, nack});
    check8("busy in frame", 8'h01, {7'h00, seen_busy});
    // the last notice lags the eighth fall by a few clocks
    repeat (8) @(posedge clk);
    check8("busy after stop", 8'h00, {7'h00, bus_busy});
  endtask

  task automatic chk_notes(input logic [7:0] ptr, input int cnt);
    check8("notice count", cnt[7:0], 8'(nq.size()));
    for (int i = 0; i < cnt && i < nq.size(); i++) begin
      check8("notice ptr", ptr + 8'(i), nq[i][15:8]);
      check8("notice data", wbuf[i], nq[i][7:0]);
    end
    nq.delete();
  endtask

  // expected bytes packed first-byte-high
  task automatic chk_reads(input int cnt, input logic [23:0] exp);
    check8("read count", cnt[7:0], 8'(rq.size()));
    for (int i = 0; i < cnt && i < rq.size(); i++) begin
      check8("read data", exp[23-8*i -: 8], rq[i]);
    end
  endtask

  initial begin
    int n;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    check8("idle bus", 8'h00, {7'h00, bus_busy});
    wbuf = '{8'hA5, 8'h3C, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    run_cmd(1'b0, `ITR_REG_BASE, 8'h03);
    chk_notes(`ITR_REG_BASE, 3);
    run_cmd(1'b1, `ITR_REG_BASE, 8'h03);
    chk_reads(3, 24'hA53CF0);
    run_cmd(1'b1, `ITR_REG_BASE + 8'h01, 8'h01);
    chk_reads(1, 24'h3C0000);
    // top of the window, then one past it reads as zero
    wbuf[0] = 8'h5A;
    wbuf[1] = 8'hC3;
    run_cmd(1'b0, LASTP - 8'h01, 8'h02);
    chk_notes(LASTP - 8'h01, 2);
    run_cmd(1'b1, LASTP - 8'h01, 8'h03);
    chk_reads(3, 24'h5AC300);
    // foreign address: no acknowledge, nothing written
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_ptr <= `ITR_REG_BASE;
    cmd_len <= 8'h01;
    wdata <= 8'h77;
    cmd_valid_b <= 1'b1;
    @(posedge clk);
    cmd_valid_b <= 1'b0;
    n = 0;
    while (done_b !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check8("foreign nack", 8'h01, {7'h00, nack_b});
    repeat (8) @(posedge clk);
    check8("foreign writes", 8'h00, stray[7:0]);
    report_and_stop();
  end

  // watchdog well beyond the expected run of about 16000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("BAD watchdog exp done got timeout");
    report_and_stop();
  end
endmodule

`default_nettype wire
